// ---- hdl/udc_regs.vh ----
// Purpose: constants for the up/down threshold counter
// Assumes: 50 MHz ref_clk, one scan tick input per cycle of the program
// Notes:   count range is the eight-digit decimal maximum
`ifndef UDC_REGS_VH
`define UDC_REGS_VH

`define UDC_CNT_W      27
`define UDC_CNT_MAX    27'h5F5_E0FF
`define UDC_CNT_ZERO   27'h000_0000
`define UDC_CNT_ONE    27'h000_0001
`define UDC_DIR_UP     1'b0
`define UDC_DIR_DOWN   1'b1
`define UDC_STORE_AW   1
`define UDC_SLOT_CNT   1'b0
`define UDC_SLOT_OUT   1'b1

`endif

// ---- hdl/udc_retain_mem.v ----
// Purpose: small retained store for count and output state
// Assumes: contents survive loss of the block's own reset
// Notes:   read data are registered; no reset on the array on purpose
`timescale 1ns/1ns
`include "udc_regs.vh"

module udc_retain_mem
(
    // Clock
    input  wire                     ref_clk,
    input  wire                     clk_en,
    // Write port
    input  wire                     wr_en,
    input  wire [`UDC_STORE_AW-1:0] wr_addr,
    input  wire [`UDC_CNT_W-1:0]    wr_data,
    // Read port
    input  wire [`UDC_STORE_AW-1:0] rd_addr,
    output reg  [`UDC_CNT_W-1:0]    rd_data
);

    reg [`UDC_CNT_W-1:0] mem [0:(1<<`UDC_STORE_AW)-1];

    always @(posedge ref_clk)
    begin
        if (clk_en)
        begin
            if (wr_en)
                mem[wr_addr] <= wr_data;
            rd_data <= mem[rd_addr];
        end
    end

endmodule

// ---- hdl/udc_counter.v ----
// Purpose: scan-driven up/down event counter with two-threshold output
// Assumes: all inputs synchronous to ref_clk; scan_tick pulses once per scan
// Notes:   retention restores count and output from udc_retain_mem at power-up
//          store writes are held off while rst_b is low or a restore runs
`timescale 1ns/1ns
`include "udc_regs.vh"

module udc_counter
(
    // Clock and reset
    input  wire                  ref_clk,
    input  wire                  rst_b,
    input  wire                  clk_en,
    // Power-up restore request (one pulse after power returns)
    input  wire                  power_up,
    // Scan cycle
    input  wire                  scan_tick,
    // Function inputs
    input  wire                  count_in,
    input  wire                  dir_in,
    input  wire                  clear_in,
    // Configuration
    input  wire [`UDC_CNT_W-1:0] switch_level,
    input  wire [`UDC_CNT_W-1:0] release_level,
    input  wire [`UDC_CNT_W-1:0] initial_count,
    input  wire                  retain_en,
    // Results
    output reg  [`UDC_CNT_W-1:0] count_q,
    output reg                   out_q
);

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    function [`UDC_CNT_W-1:0] clamp;
        input [`UDC_CNT_W-1:0] v;
        begin
            clamp = (v > `UDC_CNT_MAX) ? `UDC_CNT_MAX : v;
        end
    endfunction

    //------------------------------------------------------------
    // Restore sequence states
    //------------------------------------------------------------
    localparam [1:0] ST_RUN   = 2'b00;
    localparam [1:0] ST_RD_C  = 2'b01;
    localparam [1:0] ST_RD_O  = 2'b10;
    localparam [1:0] ST_DONE  = 2'b11;
    // ST_RD_C reads the count slot, ST_RD_O loads it, ST_DONE loads the output

    reg  [1:0]            state_q;
    reg  [1:0]            state_d;
    reg                   cnt_prev_q;
    reg                   loaded_q;
    reg  [`UDC_CNT_W-1:0] count_d;
    reg                   out_d;
    reg                   wr_en;
    reg                   wr_addr;
    reg  [`UDC_CNT_W-1:0] wr_data;
    wire [`UDC_CNT_W-1:0] rd_data;
    wire                  rise;
    wire [`UDC_CNT_W-1:0] sw_c;
    wire [`UDC_CNT_W-1:0] rl_c;
    wire                  restoring;
    wire                  rd_addr;
    wire                  mem_wr_en;

    assign sw_c      = clamp(switch_level);
    assign rl_c      = clamp(release_level);
    assign rise      = count_in & ~cnt_prev_q;
    assign restoring = (state_q != ST_RUN);

    //------------------------------------------------------------
    // Retained store
    //------------------------------------------------------------
    // Count slot is read on the ST_RD_C step, output slot on every other,
    // so each restore step finds its own word already in rd_data
    assign rd_addr   = (state_q == ST_RD_C) ? `UDC_SLOT_CNT : `UDC_SLOT_OUT;
    // No shadow writes in reset: the store has to outlive it
    assign mem_wr_en = wr_en & rst_b;

    udc_retain_mem u_mem
    (
        .ref_clk (ref_clk),
        .clk_en  (clk_en),
        .wr_en   (mem_wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------
    always @*
    begin
        state_d = state_q;
        count_d = count_q;
        out_d   = out_q;
        wr_en   = 1'b0;
        wr_addr = `UDC_SLOT_CNT;
        wr_data = count_q;
        case (state_q)
            ST_RUN:
            begin
                if (power_up && retain_en)
                begin
                    // Store left untouched until both slots are read back
                    state_d = ST_RD_C;
                end
                else
                begin
                    if (clear_in)
                    begin
                        count_d = `UDC_CNT_ZERO;
                        out_d   = 1'b0;
                    end
                    else
                    begin
                        if (!loaded_q)
                            count_d = clamp(initial_count);
                        if (rise && loaded_q)
                        begin
                            // Saturate rather than wrap
                            if (dir_in == `UDC_DIR_UP)
                            begin
                                if (count_q < `UDC_CNT_MAX)
                                    count_d = count_q + `UDC_CNT_ONE;
                            end
                            else if (count_q != `UDC_CNT_ZERO)
                                count_d = count_q - `UDC_CNT_ONE;
                        end
                        // Only the scan tick samples the count
                        if (scan_tick)
                        begin
                            if (sw_c >= rl_c)
                            begin
                                if (count_q >= sw_c)
                                    out_d = 1'b1;
                                else if (count_q < rl_c)
                                    out_d = 1'b0;
                            end
                            else
                                out_d = (count_q >= sw_c) && (count_q <= rl_c);
                        end
                    end
                    // Shadow every cycle: the count when it moves, else the output.
                    // An output change that lands with a count step is saved a
                    // cycle later; count steps never come back to back.
                    wr_en = 1'b1;
                    if (count_d != count_q)
                        wr_data = count_d;
                    else
                    begin
                        wr_addr = `UDC_SLOT_OUT;
                        wr_data = {{(`UDC_CNT_W-1){1'b0}}, out_d};
                    end
                end
            end
            ST_RD_C:
                state_d = ST_RD_O;
            ST_RD_O:
            begin
                // Count slot arrives from the read issued in ST_RD_C
                count_d = clamp(rd_data);
                state_d = ST_DONE;
            end
            ST_DONE:
            begin
                // Output slot arrives from the read issued in ST_RD_O
                out_d   = rd_data[0];
                state_d = ST_RUN;
            end
            default:
                state_d = ST_RUN;
        endcase
    end

    //------------------------------------------------------------
    // State registers
    //------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            state_q    <= ST_RUN;
            count_q    <= `UDC_CNT_ZERO;
            out_q      <= 1'b0;
            cnt_prev_q <= 1'b0;
            loaded_q   <= 1'b0;
        end
        // clk_en low freezes every register, the store included
        else if (clk_en)
        begin
            state_q    <= state_d;
            count_q    <= count_d;
            out_q      <= out_d;
            cnt_prev_q <= count_in;
            // Initial value is taken once; a clear restarts from zero
            if (clear_in || restoring)
                loaded_q <= 1'b1;
            else if (!loaded_q)
                loaded_q <= 1'b1;
        end
    end

endmodule

// ---- verification/udc_counter_monitor.sv ----
// Purpose: port checker for udc_counter
// Assumes: inputs ignored for the three restore cycles after power_up
// Notes:   bound from the bench top file
`timescale 1ns/1ns
`include "udc_regs.vh"
module udc_counter_monitor
(
    // Clock and control
    input wire                  ref_clk,
    input wire                  rst_b,
    input wire                  clk_en,
    input wire                  power_up,
    input wire                  scan_tick,
    input wire                  count_in,
    input wire                  dir_in,
    input wire                  clear_in,
    input wire                  retain_en,
    // Levels
    input wire [`UDC_CNT_W-1:0] switch_level,
    input wire [`UDC_CNT_W-1:0] release_level,
    input wire [`UDC_CNT_W-1:0] initial_count,
    // Results
    input wire [`UDC_CNT_W-1:0] count_q,
    input wire                  out_q
);
    reg       cin_q;
    reg       rst_q;
    reg [2:0] pu_q;
    always @(posedge ref_clk)
    begin
        cin_q <= count_in;
        rst_q <= rst_b;
        // Restore steps ignore the inputs for three cycles
        pu_q  <= rst_b ? {pu_q[1:0], power_up & retain_en} : 3'b000;
    end
    // First cycle after release loads the start value, so it is left out
    wire rise        = count_in & ~cin_q;
    wire restore_win = (power_up & retain_en) | (|pu_q);
    wire go          = clk_en & ~clear_in & ~restore_win & rst_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    AST_CLEAR_ZERO: assert property (clk_en && clear_in && !restore_win |=> count_q == 0 && !out_q)
        else $error("clear did not zero");
    AST_NO_EDGE_HOLD: assert property (go && !rise |=> $stable(count_q))
        else $error("count moved without rising edge");
    AST_COUNT_UP: assert property (go && rise && !dir_in && count_q != `UDC_CNT_MAX
        |=> count_q == $past(count_q) + `UDC_CNT_ONE) else $error("up step wrong");
    AST_COUNT_DOWN: assert property (go && rise && dir_in && count_q != 0
        |=> count_q == $past(count_q) - `UDC_CNT_ONE) else $error("down step wrong");
    AST_SAT_ENDS: assert property (go && rise && (dir_in ? count_q == 0 :
        count_q == `UDC_CNT_MAX) |=> $stable(count_q)) else $error("count wrapped");
    AST_LOAD_INIT: assert property ($rose(rst_b) && clk_en && !clear_in && !restore_win
        |=> count_q == $past(initial_count)) else $error("start value not loaded");
    AST_SCAN_ONLY: assert property (go && !scan_tick |=> $stable(out_q))
        else $error("output moved off scan");
    AST_WINDOW: assert property (go && scan_tick && switch_level < release_level
        |=> out_q == ($past(count_q) >= $past(switch_level) &&
        $past(count_q) <= $past(release_level))) else $error("window output wrong");
    AST_HYSTERESIS: assert property (go && scan_tick && switch_level >= release_level
        |=> out_q == ($past(count_q) >= $past(switch_level) ||
        ($past(count_q) >= $past(release_level) && $past(out_q)))) else $error("hysteresis wrong");
endmodule

// ---- verification/udc_pulse_src.sv ----
// Purpose: pulse-producing input terminal feeding count_in
// Assumes: fire driven at the falling edge
// Notes:   always leaves one low cycle between highs
`timescale 1ns/1ns
module udc_pulse_src
(
    input  wire ref_clk,
    input  wire fire,
    output reg  count_in
);
    initial count_in = 1'b0;
    always @(posedge ref_clk)
        count_in <= fire & ~count_in;
endmodule

// ---- verification/udc_counter_tb.sv ----
// Purpose: self-checking bench for udc_counter
// Assumes: clk_en held high, power_up pulsed only at a reset release
// Notes:   seeded xorshift picks the first release level, directions and retain_en
`timescale 1ns/1ns
`include "udc_regs.vh"
module udc_counter_tb;
    reg                  ref_clk = 0, rst_b = 0, scan_tick = 0, dir_in = 0;
    reg                  clear_in = 0, retain_en = 0, fire = 0, exp_out = 0, power_up = 0;
    reg [`UDC_CNT_W-1:0] sw_lvl, rel_lvl, init_cnt, exp_cnt;
    reg [31:0]           seed = 32'h0000_0976;
    integer              n_errors = 0, check_count = 0, i;
    wire                 count_in, out_q;
    wire [`UDC_CNT_W-1:0] count_q;
    always #10 ref_clk = ~ref_clk;
    udc_pulse_src SRC (.ref_clk(ref_clk), .fire(fire), .count_in(count_in));
    udc_counter DUT (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1), .power_up(power_up),
        .scan_tick(scan_tick), .count_in(count_in), .dir_in(dir_in), .clear_in(clear_in),
        .switch_level(sw_lvl), .release_level(rel_lvl), .initial_count(init_cnt),
        .retain_en(retain_en), .count_q(count_q), .out_q(out_q));
    function [31:0] xs(input [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    function [26:0] nxt(input [26:0] c, input d);
        nxt = d ? (c == 0 ? c : c - 1) : (c == `UDC_CNT_MAX ? c : c + 1);
    endfunction
    function eo(input [26:0] c, input o);
        eo = sw_lvl < rel_lvl ? c >= sw_lvl && c <= rel_lvl : c >= sw_lvl || (c >= rel_lvl && o);
    endfunction
    task chk(input [26:0] seen, input [26:0] exp);
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task pulse(input d);
        @(negedge ref_clk) {dir_in, fire} = {d, 1'b1};
        @(negedge ref_clk) fire = 0;
        @(negedge ref_clk) exp_cnt = nxt(exp_cnt, d);
        chk(count_q, exp_cnt);
    endtask
    task scan;
        @(negedge ref_clk) scan_tick = 1;
        @(negedge ref_clk) scan_tick = 0;
        exp_out = eo(exp_cnt, exp_out);
        chk({26'd0, out_q}, {26'd0, exp_out});
    endtask
    task clr;
        @(negedge ref_clk) {clear_in, fire} = 2'b11;
        @(negedge ref_clk) fire = 0;
        repeat (2) @(negedge ref_clk);
        clear_in = 0;
        {exp_cnt, exp_out} = 0;
        chk(count_q, 0);
        chk({26'd0, out_q}, 27'd0);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        seed = xs(seed);
        {init_cnt, sw_lvl, rel_lvl} = {`UDC_CNT_MAX - 27'd1, `UDC_CNT_MAX, 17'd0, seed[9:0]};
        exp_cnt = init_cnt;
        repeat (3) @(negedge ref_clk);
        rst_b = 1;
        repeat (2) @(negedge ref_clk);
        chk(count_q, init_cnt);
        pulse(0);
        pulse(0);
        scan;
        for (i = 0; i < 40; i = i + 1)
        begin
            seed = xs(seed);
            retain_en = seed[1];
            pulse(seed[0]);
        end
        scan;
        $display("limits and random run done");
        clr;
        pulse(1);
        {sw_lvl, rel_lvl} = {27'd3, 27'd5};
        for (i = 0; i < 7; i = i + 1)
        begin
            pulse(0);
            scan;
        end
        {sw_lvl, rel_lvl} = {27'd6, 27'd2};
        for (i = 0; i < 9; i = i + 1)
        begin
            pulse(1);
            scan;
        end
        $display("window and hysteresis done");
        clr;
        {sw_lvl, rel_lvl} = {27'd3, 27'd4};
        repeat (6) pulse(0);
        scan;
        $display("pass-through done");
        {sw_lvl, rel_lvl} = {27'd2, 27'd1};
        scan;
        // Power loss with retention: count and output come back
        {rst_b, retain_en} = 2'b01;
        repeat (3) @(negedge ref_clk);
        {rst_b, power_up} = 2'b11;
        @(negedge ref_clk) power_up = 0;
        repeat (3) @(negedge ref_clk);
        chk(count_q, exp_cnt);
        chk({26'd0, out_q}, {26'd0, exp_out});
        // Power loss without retention: start value again, output low
        {rst_b, retain_en} = 2'b00;
        repeat (3) @(negedge ref_clk);
        {rst_b, power_up} = 2'b11;
        @(negedge ref_clk) power_up = 0;
        @(negedge ref_clk);
        chk(count_q, init_cnt);
        chk({26'd0, out_q}, 27'd0);
        $display("retention done");
        print_verdict;
    end
    initial
    begin
        #500000;
        n_errors = n_errors + 1;
        print_verdict;
    end
endmodule
bind udc_counter udc_counter_monitor u_mon (.ref_clk, .rst_b, .clk_en, .power_up, .scan_tick,
    .count_in, .dir_in, .clear_in, .retain_en, .switch_level, .release_level,
    .initial_count, .count_q, .out_q);
